// file: cim_pkg.sv
// Package with register map, field positions, reset values and state codes
package cim_pkg;
	// ------------------------------------------------------------
	// Register offsets (byte addresses on the register port)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CHIP_IDENTITY = 8'hc0;
	localparam logic [7:0] OFS_GLOBAL_CHIP_CONTROL = 8'hc6;
	localparam logic [7:0] OFS_INDIRECT_COMMAND = 8'hc8;
	localparam logic [7:0] OFS_INDIRECT_DATA_LOW = 8'hd0;
	localparam logic [7:0] OFS_INDIRECT_DATA_HIGH = 8'hd2;
	localparam logic [7:0] OFS_WAKE_EVENT_CONTROL = 8'hd4;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ID_FAMILY_LSB = 8;
	localparam int ID_CHIP_LSB = 4;
	localparam int ID_REV_LSB = 1;
	localparam int GCC_LIGHT_MODE_BIT = 9;
	localparam int CMD_READ_EN_BIT = 12;
	localparam int CMD_TABLE_LSB = 10;
	localparam int CMD_ADDR_LSB = 0;
	localparam int WEC_DELAY_EN_BIT = 14;
	localparam int WEC_POLARITY_BIT = 12;
	localparam int WEC_EN_FRAME_BIT = 11;
	localparam int WEC_EN_REMOTE_BIT = 10;
	localparam int WEC_EN_LINK_BIT = 9;
	localparam int WEC_EN_ENERGY_BIT = 8;
	localparam int WEC_AUTO_WAKE_BIT = 7;

	// ------------------------------------------------------------
	// Codes, masks and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] TABLE_STAT_COUNTERS = 2'h3;
	localparam logic [15:0] WEC_WRITE_MASK = 16'h7fff;
	localparam logic [15:0] RST_CHIP_IDENTITY_LOW = 16'h0000;
	localparam logic [15:0] RST_GLOBAL_CHIP_CONTROL = 16'h0835;
	localparam logic [15:0] RST_INDIRECT_COMMAND = 16'h0000;
	localparam logic [15:0] RST_INDIRECT_DATA = 16'h0000;
	localparam logic [15:0] RST_WAKE_EVENT_CONTROL = 16'h0000;

	// Counter bank read sequencer
	typedef enum logic [0:0] {
		CIM_RD_IDLE = 1'b0,
		CIM_RD_DONE = 1'b1
	} cim_rd_state_e;
endpackage : cim_pkg

// file: cim_mib_if.sv
// Interface between the register bank and the statistics counter bank
`timescale 1ns/1ps
interface cim_mib_if #(
	parameter int ADDR_W = 5,
	parameter int DATA_W = 32
);
	logic rd_req; // One-cycle read-and-clear request
	logic [ADDR_W-1:0] rd_addr; // Counter index
	logic rd_done; // High the cycle after each request, rd_data valid
	logic [DATA_W-1:0] rd_data; // Captured counter value

	modport bank (input rd_req, input rd_addr, output rd_done, output rd_data);
	modport ctrl (output rd_req, output rd_addr, input rd_done, input rd_data);
endinterface : cim_mib_if

// file: cim_mib_bank.sv
// Bank of statistics counters with read-and-clear access
`timescale 1ns/1ps
module cim_mib_bank #(
	parameter int NUM_CNT = 32,
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [NUM_CNT-1:0] cnt_inc,
	cim_mib_if.bank mib
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt [NUM_CNT]; // Counter storage, flops
	logic [CNT_W-1:0] cap; // Value captured on a read
	cim_pkg::cim_rd_state_e state; // Read sequencer

	assign mib.rd_data = cap;
	assign mib.rd_done = (state == cim_pkg::CIM_RD_DONE);

	// Count up, and clear on read; an increment in the clear cycle survives as one
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < NUM_CNT; i++) begin
			if (sys_rst) begin
				cnt[i] <= '0;
			end else if (mib.rd_req && (int'(mib.rd_addr) == i)) begin
				cnt[i] <= {{(CNT_W-1){1'b0}}, cnt_inc[i]};
			end else if (cnt_inc[i]) begin
				cnt[i] <= cnt[i] + CNT_W'(1);
			end
		end
	end

	// Capture the addressed counter and flag completion next cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cap <= '0;
			state <= cim_pkg::CIM_RD_IDLE;
		end else begin
			case (state)
				cim_pkg::CIM_RD_IDLE: begin
					if (mib.rd_req) begin
						cap <= cnt[mib.rd_addr];
						state <= cim_pkg::CIM_RD_DONE;
					end
				end
				default: begin
					// A command in the done cycle is captured too, or its cleared value would be lost
					if (mib.rd_req) begin
						cap <= cnt[mib.rd_addr];
					end else begin
						state <= cim_pkg::CIM_RD_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	read_clears_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mib.rd_req && !cnt_inc[mib.rd_addr] |=> cnt[$past(mib.rd_addr)] == '0)
		else $error("counter not cleared after read");
	read_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mib.rd_req && state == cim_pkg::CIM_RD_IDLE
		|=> mib.rd_done && mib.rd_data == $past(cnt[mib.rd_addr]))
		else $error("read data does not match addressed counter");
endmodule : cim_mib_bank

// file: cim_regs.sv
// Chip identity, global control, counter access and wake event register group
//
// Operation
// - Identity fields read-only, writes ignored
// - Light mode bit picks indicator meanings
// - A command write launches a read only with read enable and table 11
// - Read enable reads then clears counter
// - Only table code 11 selects counters
// - Address bits pick one of 32 counters
// - Data low shows counter bits 15-0
// - Data high shows counter bits 31-16
// - Delay enable holds wake until ready
// - Delay honoured only with auto wake-up
// - Polarity bit sets wake output level
// - Enables gate frame, remote, link events
// - Bit 8 gates signal energy event
// - Bit 7 enables automatic wake-up
//
// Usage notes
// A counter read needs two cycles before the data words hold the value.
// A second command in the done cycle is captured as well, so no value is lost.
// Host writes to the data words stand unless a counter load lands that cycle.
// Any write to the wake register drops a pending event; a new event wins.
// Unmapped addresses read as zero and ignore writes.
// Reads are registered: data is valid one cycle after the read strobe.
`timescale 1ns/1ps
module cim_regs #(
	parameter logic [7:0] FAMILY_CODE = 8'h5a, // Arbitrary value
	parameter logic [3:0] CHIP_CODE = 4'h3, // Arbitrary value
	parameter logic [2:0] REVISION_CODE = 3'h1, // Arbitrary value
	parameter int NUM_CNT = 32,
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [1:0] reg_be,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [NUM_CNT-1:0] cnt_inc,
	input wire logic speed_100,
	input wire logic link_up,
	input wire logic activity,
	output logic indicator_light_1,
	output logic indicator_light_0,
	input wire logic wake_frame_evt,
	input wire logic remote_pkt_evt,
	input wire logic link_up_evt,
	input wire logic energy_evt,
	input wire logic clocks_ready,
	output logic auto_wake_enable,
	output logic wake_event_output
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Merge write data into a register under byte enables
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic id_spare; // Writable reserved bit 0 of the identity register
	logic [15:0] global_chip_control; // Global control, all bits stored
	logic [15:0] indirect_command; // Last command written
	logic [15:0] indirect_data_low; // Counter data, low word
	logic [15:0] indirect_data_high; // Counter data, high word
	logic [15:0] wake_event_control; // Wake event control
	logic wake_pending; // Sticky: an enabled wake event was seen

	// Counter bank link; a request is one cycle wide and done follows a cycle later
	cim_mib_if #(.ADDR_W(5), .DATA_W(CNT_W)) mib ();

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire hit_id = (reg_addr == cim_pkg::OFS_CHIP_IDENTITY);
	wire hit_gcc = (reg_addr == cim_pkg::OFS_GLOBAL_CHIP_CONTROL);
	wire hit_cmd = (reg_addr == cim_pkg::OFS_INDIRECT_COMMAND);
	wire hit_dlo = (reg_addr == cim_pkg::OFS_INDIRECT_DATA_LOW);
	wire hit_dhi = (reg_addr == cim_pkg::OFS_INDIRECT_DATA_HIGH);
	wire hit_wec = (reg_addr == cim_pkg::OFS_WAKE_EVENT_CONTROL);

	wire [15:0] id_word = {FAMILY_CODE, CHIP_CODE, REVISION_CODE, id_spare};
	wire [15:0] next_cmd = merge(indirect_command, reg_wdata, reg_be);

	// Read mux; unmapped addresses read as zero
	wire [15:0] rd_mux = hit_id ? id_word :
		hit_gcc ? global_chip_control :
		hit_cmd ? indirect_command :
		hit_dlo ? indirect_data_low :
		hit_dhi ? indirect_data_high :
		hit_wec ? wake_event_control : 16'h0000;

	// A command launches a counter read only with read enable and the counter table
	wire cmd_write = reg_wr && hit_cmd;
	wire cmd_is_read = next_cmd[cim_pkg::CMD_READ_EN_BIT] &&
		(next_cmd[cim_pkg::CMD_TABLE_LSB +: 2] == cim_pkg::TABLE_STAT_COUNTERS);
	assign mib.rd_req = cmd_write && cmd_is_read;
	assign mib.rd_addr = next_cmd[cim_pkg::CMD_ADDR_LSB +: 5];

	// Statistics counters behind the indirect port
	cim_mib_bank #(.NUM_CNT(NUM_CNT), .CNT_W(CNT_W)) u_bank (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cnt_inc(cnt_inc),
		.mib(mib.bank)
	);

	// ------------------------------------------------------------
	// Wake event decode
	// ------------------------------------------------------------
	wire wec_pol = wake_event_control[cim_pkg::WEC_POLARITY_BIT];
	wire wec_auto = wake_event_control[cim_pkg::WEC_AUTO_WAKE_BIT];
	wire wec_delay = wake_event_control[cim_pkg::WEC_DELAY_EN_BIT];
	wire wake_hit = (wake_frame_evt && wake_event_control[cim_pkg::WEC_EN_FRAME_BIT]) ||
		(remote_pkt_evt && wake_event_control[cim_pkg::WEC_EN_REMOTE_BIT]) ||
		(link_up_evt && wake_event_control[cim_pkg::WEC_EN_LINK_BIT]) ||
		(energy_evt && wake_event_control[cim_pkg::WEC_EN_ENERGY_BIT]);
	// Delay only applies with auto wake-up set; then wait for clocks_ready
	wire wake_gate = !(wec_delay && wec_auto) || clocks_ready;
	wire wake_active = wake_pending && wake_gate;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Host writes; identity fields have no write path at all
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			id_spare <= 1'b0;
			global_chip_control <= cim_pkg::RST_GLOBAL_CHIP_CONTROL;
			indirect_command <= cim_pkg::RST_INDIRECT_COMMAND;
			wake_event_control <= cim_pkg::RST_WAKE_EVENT_CONTROL;
		end else if (reg_wr) begin
			if (hit_id && reg_be[0]) begin
				id_spare <= reg_wdata[0];
			end
			if (hit_gcc) begin
				global_chip_control <= merge(global_chip_control, reg_wdata, reg_be);
			end
			if (hit_cmd) begin
				indirect_command <= next_cmd;
			end
			if (hit_wec) begin
				// Bit 15 is read-only and stays zero
				wake_event_control <= merge(wake_event_control, reg_wdata, reg_be) &
					cim_pkg::WEC_WRITE_MASK;
			end
		end
	end

	// Data words: host may write them; a finished counter read overwrites both
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			indirect_data_low <= cim_pkg::RST_INDIRECT_DATA;
			indirect_data_high <= cim_pkg::RST_INDIRECT_DATA;
		end else if (mib.rd_done) begin
			indirect_data_low <= mib.rd_data[15:0];
			indirect_data_high <= mib.rd_data[31:16];
		end else if (reg_wr) begin
			if (hit_dlo) begin
				indirect_data_low <= merge(indirect_data_low, reg_wdata, reg_be);
			end
			if (hit_dhi) begin
				indirect_data_high <= merge(indirect_data_high, reg_wdata, reg_be);
			end
		end
	end

	// Read data is registered, valid the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Wake event output
	// ------------------------------------------------------------
	// Pending is cleared by any write to the wake register; a new event wins over it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wake_pending <= 1'b0;
		end else if (wake_hit) begin
			wake_pending <= 1'b1;
		end else if (reg_wr && hit_wec) begin
			wake_pending <= 1'b0;
		end
	end

	// Output from a flop; the inactive level follows the polarity bit
	// Reset level is high, which is inactive for the reset polarity of zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wake_event_output <= 1'b1;
			auto_wake_enable <= 1'b0;
		end else begin
			wake_event_output <= wake_active ? wec_pol : !wec_pol;
			auto_wake_enable <= wec_auto;
		end
	end

	// ------------------------------------------------------------
	// Indicator lights
	// ------------------------------------------------------------
	// Mode 0: speed on light 1, link lit and dark while active on light 0
	// Mode 1: activity on light 1, link on light 0
	wire light_mode_select = global_chip_control[cim_pkg::GCC_LIGHT_MODE_BIT];
	wire next_light_1 = light_mode_select ? activity : speed_100;
	wire next_light_0 = light_mode_select ? link_up : (link_up && !activity);

	// Lights are registered, so they trail the line status by one cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			indicator_light_1 <= 1'b0;
			indicator_light_0 <= 1'b0;
		end else begin
			indicator_light_1 <= next_light_1;
			indicator_light_0 <= next_light_0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	id_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reg_rd && hit_id |=> reg_rdata[15:1] == {FAMILY_CODE, CHIP_CODE, REVISION_CODE})
		else $error("identity fields read wrong");
	light_mode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		global_chip_control[cim_pkg::GCC_LIGHT_MODE_BIT] && activity |=> indicator_light_1)
		else $error("light 1 does not show activity in mode 1");
	cmd_launch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_write && cmd_is_read |=> mib.rd_done ##1 indirect_command == $past(next_cmd, 2))
		else $error("counter read not launched");
	cmd_noop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_write && !next_cmd[cim_pkg::CMD_READ_EN_BIT] && !mib.rd_done
		|=> !mib.rd_done && $stable(indirect_data_low))
		else $error("command without read enable changed data");
	table_code_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_write && next_cmd[cim_pkg::CMD_TABLE_LSB +: 2] != cim_pkg::TABLE_STAT_COUNTERS
		|-> !mib.rd_req)
		else $error("reserved table code launched a read");
	data_words_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mib.rd_done |=> {indirect_data_high, indirect_data_low} == $past(mib.rd_data))
		else $error("data words do not match counter");
	wake_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wec_delay && wec_auto && !clocks_ready |=> wake_event_output == !$past(wec_pol))
		else $error("wake asserted before clocks ready");
	wake_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wake_frame_evt && wake_event_control[cim_pkg::WEC_EN_FRAME_BIT] && !wec_delay
		##1 $stable(wec_pol) |=> wake_event_output == $past(wec_pol))
		else $error("wake output not at active level after event");
	energy_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		energy_evt && !wake_event_control[cim_pkg::WEC_EN_ENERGY_BIT] && !wake_pending &&
		!wake_frame_evt && !remote_pkt_evt && !link_up_evt |=> !wake_pending)
		else $error("masked energy event raised wake");
	auto_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |=> auto_wake_enable == $past(wec_auto))
		else $error("auto wake-up output does not follow bit 7");
	// Lights follow the status lines one cycle late in both modes
	light_speed_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!light_mode_select |=> indicator_light_1 == $past(speed_100))
		else $error("light 1 does not show speed in mode 0");
	light_link_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		light_mode_select |=> indicator_light_0 == $past(link_up))
		else $error("light 0 does not show link in mode 1");
	// Command and data words change only on a write or a finished load
	cmd_stored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmd_write |=> indirect_command == $past(next_cmd))
		else $error("command register does not hold the written value");
	data_low_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!mib.rd_done && !(reg_wr && hit_dlo) |=> $stable(indirect_data_low))
		else $error("data low word changed without a load or write");
	data_high_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!mib.rd_done && !(reg_wr && hit_dhi) |=> $stable(indirect_data_high))
		else $error("data high word changed without a load or write");
	// Wake output tracks the pending flag, the delay gate and the polarity
	link_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		link_up_evt && wake_event_control[cim_pkg::WEC_EN_LINK_BIT] |=> wake_pending)
		else $error("enabled link event did not raise wake");
	energy_wake_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		energy_evt && wake_event_control[cim_pkg::WEC_EN_ENERGY_BIT] |=> wake_pending)
		else $error("enabled energy event did not raise wake");
	wake_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reg_wr && hit_wec && !wake_hit |=> !wake_pending)
		else $error("write to wake register did not drop the pending event");
	wake_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!wake_pending |=> wake_event_output == !$past(wec_pol))
		else $error("wake output not at inactive level while idle");
	wake_free_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wake_pending && !(wec_delay && wec_auto) |=> wake_event_output == $past(wec_pol))
		else $error("wake output held although no delay applies");
endmodule : cim_regs

// file: tb_top.sv
// Self-checking testbench for the chip register group
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	localparam logic [7:0] FAM = 8'hc4; // Arbitrary value
	localparam logic [3:0] CHP = 4'h9; // Arbitrary value
	localparam logic [2:0] REV = 3'h5; // Arbitrary value
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] reg_be = 2'h3;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [31:0] cnt_inc = 32'h0;
	logic speed_100 = 1'b0;
	logic link_up = 1'b0;
	logic activity = 1'b0;
	logic indicator_light_1;
	logic indicator_light_0;
	logic [3:0] evts = 4'h0; // Frame, remote, link, energy
	logic clocks_ready = 1'b1;
	logic auto_wake_enable;
	logic wake_event_output;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [15:0] rdat;

	cim_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REVISION_CODE(REV)) u_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cnt_inc(cnt_inc), .speed_100(speed_100), .link_up(link_up), .activity(activity),
		.indicator_light_1(indicator_light_1), .indicator_light_0(indicator_light_0),
		.wake_frame_evt(evts[3]), .remote_pkt_evt(evts[2]), .link_up_evt(evts[1]),
		.energy_evt(evts[0]), .clocks_ready(clocks_ready),
		.auto_wake_enable(auto_wake_enable), .wake_event_output(wake_event_output));

	// Free-running clock, 100 MHz
	always #5 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Wait n edges, then step off the edge so inputs never race it
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	// One-cycle write strobe with byte enables
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
		reg_addr = a;
		reg_wdata = d;
		reg_be = be;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr

	// Read strobe; data is registered, so it is taken one edge later
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		cyc(1);
		d = reg_rdata;
	endtask : rd

	// Closing report, reached from the main flow or the hang guard
	task automatic test_done;
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			$display("Error at %0t: run timed out", $time);
			test_done();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Identity fields ignore writes; only bit 0 is stored; unmapped reads 0
	task automatic t_identity;
		`CHK(reg_rdata, 16'h0000)
		rd(cim_pkg::OFS_CHIP_IDENTITY, rdat);
		`CHK(rdat, {FAM, CHP, REV, 1'b0})
		wr(cim_pkg::OFS_CHIP_IDENTITY, 16'hffff);
		rd(cim_pkg::OFS_CHIP_IDENTITY, rdat);
		`CHK(rdat, {FAM, CHP, REV, 1'b1})
		rd(8'hc2, rdat);
		`CHK(rdat, 16'h0000)
		$display("identity test done");
	endtask : t_identity

	// Light meanings in both modes, plus a low-byte-only write
	task automatic t_lights;
		rd(cim_pkg::OFS_GLOBAL_CHIP_CONTROL, rdat);
		`CHK(rdat, 16'h0835)
		speed_100 = 1'b1;
		link_up = 1'b1;
		activity = 1'b0;
		cyc(2);
		`CHK({indicator_light_1, indicator_light_0}, 2'b11)
		activity = 1'b1;
		speed_100 = 1'b0;
		cyc(2);
		`CHK({indicator_light_1, indicator_light_0}, 2'b00)
		wr(cim_pkg::OFS_GLOBAL_CHIP_CONTROL, 16'h0a35);
		cyc(2);
		`CHK({indicator_light_1, indicator_light_0}, 2'b11)
		activity = 1'b0;
		cyc(2);
		`CHK({indicator_light_1, indicator_light_0}, 2'b01)
		wr(cim_pkg::OFS_GLOBAL_CHIP_CONTROL, 16'hffff, 2'h1);
		rd(cim_pkg::OFS_GLOBAL_CHIP_CONTROL, rdat);
		`CHK(rdat, 16'h0aff)
		$display("lights test done");
	endtask : t_lights

	// Issue a command, let the load land, and check both data words
	task automatic cmd_check(input logic [15:0] c, input logic [31:0] exp);
		wr(cim_pkg::OFS_INDIRECT_COMMAND, c);
		cyc(3);
		rd(cim_pkg::OFS_INDIRECT_DATA_LOW, rdat);
		`CHK(rdat, exp[15:0])
		rd(cim_pkg::OFS_INDIRECT_DATA_HIGH, rdat);
		`CHK(rdat, exp[31:16])
	endtask : cmd_check

	// Counter reads, read-clear, reserved table code and no-op command
	task automatic t_counters;
		cnt_inc = 32'h8000_0001;
		cyc(3);
		cnt_inc = 32'h8000_0000;
		cyc(4);
		cnt_inc = 32'h0;
		// A stale host value in the high word must be replaced by the load
		wr(cim_pkg::OFS_INDIRECT_DATA_HIGH, 16'hbeef);
		cyc(1);
		cmd_check(16'h1c1f, 32'd7);
		rd(cim_pkg::OFS_INDIRECT_COMMAND, rdat);
		`CHK(rdat, 16'h1c1f)
		cmd_check(16'h181f, 32'd7);
		cmd_check(16'h0c00, 32'd7);
		cmd_check(16'h1c00, 32'd3);
		cmd_check(16'h1c1f, 32'd0);
		$display("counter test done");
	endtask : t_counters

	// Program wake control, pulse one event, check the output level
	task automatic wake_case(input logic [15:0] ctl, input int i, input logic act);
		wr(cim_pkg::OFS_WAKE_EVENT_CONTROL, ctl);
		evts = 4'h1 << i;
		cyc(1);
		evts = 4'h0;
		cyc(2);
		`CHK(wake_event_output, act ~^ ctl[12])
		`CHK(auto_wake_enable, ctl[7])
	endtask : wake_case

	// Any write to wake control drops the pending event
	task automatic wake_clear(input logic [15:0] ctl);
		wr(cim_pkg::OFS_WAKE_EVENT_CONTROL, ctl);
		cyc(1);
		`CHK(wake_event_output, ~ctl[12])
	endtask : wake_clear

	// Every event enabled alone and masked alone, both polarities, delay
	task automatic t_wake;
		for (int i = 0; i < 4; i++) begin
			wake_case(16'h1000 | (16'h0100 << i), i, 1'b1);
			wake_clear(16'h1000);
			wake_case(16'h1f00 & ~(16'h0100 << i), i, 1'b0);
		end
		wake_case(16'h0800, 3, 1'b1);
		wake_clear(16'h0000);
		clocks_ready = 1'b0;
		wake_case(16'h5880, 3, 1'b0);
		clocks_ready = 1'b1;
		cyc(3);
		`CHK(wake_event_output, 1'b1)
		wake_clear(16'h1000);
		clocks_ready = 1'b0;
		wake_case(16'h5800, 3, 1'b1);
		wake_case(16'h1880, 3, 1'b1);
		clocks_ready = 1'b1;
		wake_clear(16'h1000);
		rd(cim_pkg::OFS_WAKE_EVENT_CONTROL, rdat);
		`CHK(rdat, 16'h1000)
		$display("wake test done");
	endtask : t_wake

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		cyc(1);
		t_identity();
		t_lights();
		t_counters();
		t_wake();
		test_done();
	end
endmodule : tb_top
